// [adc_calibration_sequencer.sv]
/*
 * calibration sequencer for a six-bank, three-core interleaved converter:
 * foreground, background and low-power background calibration, offset
 * calibration into the trim store, APB register slave.
 * assumes synchronous inputs, one 200 MHz clock, analog work abstracted
 * as timed steps.
 */
// Added by the designer: the address map and the APB interface to the registers.
// Functional notes
// - foreground: cores offline, output midcode
// - background keeps converting without interruption
// - six banks, paired into three cores
// - core inputs follow dual or single channel
// - core C swaps in for A and B
// - every bank calibrated: linearity, gain, offset
// - trims power up factory, readable, writable
// - foreground calibration runs after reset
// - trigger from pin or soft bit
// - background rotates spare core continuously
// - low power keeps offline core powered down
// - sleep delay before spare core wakes
// - wake delay before calibration of core
// - low power switch: automatic or user trigger
// - fg offset enable: one offset pass
// - bg offset enable: offsets corrected continuously
// - offset calibration writes trims; software must not
`timescale 1ns/1ps
`include "cal_seq_consts.svh"

module adc_calibration_sequencer
    import cal_seq_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // calibration trigger pin
    input  wire logic        cal_start_pin,
    // converter data path
    input  wire logic [11:0] core_a_data,
    input  wire logic [11:0] core_b_data,
    input  wire logic [11:0] core_c_data,
    output logic      [11:0] sample_a_ff,
    output logic      [11:0] sample_b_ff,
    // core control
    output logic      [2:0]  core_online_ff,
    output logic      [2:0]  core_power_ff,
    output logic      [5:0]  bank_cal_ff,
    output logic      [1:0]  core_a_input_ff,
    output logic      [1:0]  core_b_input_ff,
    output logic      [1:0]  core_c_input_ff,
    output logic             foreground_done_flag
);
    logic [31:0] ctrl_ff;
    logic [31:0] lp_ff;
    logic        sw_cal_start_bit;
    logic        sw_cal_start_bit_ff;
    logic        pin_ff;
    logic        done_ff;
    cal_state_e  state_ff;
    logic [15:0] cnt_ff;
    logic [2:0]  bank_ff;
    logic [2:0]  os_idx_ff;
    logic        target_ff;
    logic [11:0] trim_rd;
    logic        eng_wr;
    logic        sw_trim_wr;
    logic        trim_wr_en;
    logic [2:0]  trim_wr_idx;
    logic [11:0] trim_wr_data;
    logic [2:0]  trim_rd_idx;
    logic        apb_wr;
    logic        apb_rd_setup;
    logic        start_evt;
    logic        pin_rise;
    logic        low_power_background_mode;
    logic [15:0] spare_sleep_delay;
    logic [15:0] spare_wake_delay;
    logic [11:0] offset_est;

    // one-hot core a/b decode of the rotation target
    function automatic logic [2:0] core_bit(input logic idx);
        core_bit = idx ? 3'b010 : 3'b001;
    endfunction

    function automatic logic is_trim(input logic [11:0] a);
        is_trim = a >= `REG_TRIM_BASE && a <= `REG_TRIM_LAST && a[1:0] == 2'b00;
    endfunction

    assign low_power_background_mode = ctrl_ff[`CTRL_BG_EN] & ctrl_ff[`CTRL_LOW_POWER_BG_ENABLE];
    assign spare_sleep_delay = lp_ff[`LP_SLEEP_LSB +: 16];
    assign spare_wake_delay  = lp_ff[`LP_WAKE_LSB +: 16];
    assign sw_cal_start_bit  = sw_cal_start_bit_ff;

    // apb: zero wait states, error on unmapped address
    assign pready      = 1'b1;
    assign apb_wr      = psel & penable & pwrite;
    assign apb_rd_setup = psel & ~penable & ~pwrite;
    assign pslverr     = psel & penable & ~(paddr == `REG_CTRL || paddr == `REG_TRIG
                         || paddr == `REG_LP || paddr == `REG_STATUS || is_trim(paddr));

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_ff <= `CTRL_RESET;
            lp_ff   <= `LP_RESET;
        end else if (apb_wr && paddr == `REG_CTRL) begin
            ctrl_ff <= {23'h0, pwdata[8:0]};
        end else if (apb_wr && paddr == `REG_LP) begin
            lp_ff <= pwdata;
        end
    end

    // soft trigger bit holds; its rise is the event
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sw_cal_start_bit_ff <= 1'b0;
            pin_ff              <= 1'b0;
        end else begin
            pin_ff <= cal_start_pin;
            if (apb_wr && paddr == `REG_TRIG) begin
                sw_cal_start_bit_ff <= pwdata[0];
            end
        end
    end

    assign pin_rise  = cal_start_pin & ~pin_ff;
    // source chosen by the pin select bit
    assign start_evt = ctrl_ff[`CTRL_PIN_SEL] ? pin_rise
                     : (apb_wr && paddr == `REG_TRIG && pwdata[0] && !sw_cal_start_bit_ff);

    // software trim writes are dropped while offset calibration owns them
    assign sw_trim_wr  = apb_wr && is_trim(paddr)
                       && !ctrl_ff[`CTRL_FG_OS] && !ctrl_ff[`CTRL_BG_OS];
    assign eng_wr      = (state_ff == st_fg_offset || state_ff == st_bg_cal)
                       && cnt_ff == 16'h0 && (state_ff == st_fg_offset
                       || ctrl_ff[`CTRL_BG_OS]);
    assign offset_est  = `MIDCODE - (target_ff ? core_b_data : core_a_data);
    assign trim_wr_en  = eng_wr | sw_trim_wr;
    assign trim_wr_idx = eng_wr ? (state_ff == st_bg_cal ? {2'b00, target_ff} : os_idx_ff)
                       : 3'((paddr - `REG_TRIM_BASE) >> 2);
    assign trim_wr_data = eng_wr ? offset_est : pwdata[11:0];
    assign trim_rd_idx = 3'((paddr - `REG_TRIM_BASE) >> 2);

    trim_store u_trim (
        .clock      (clock),
        .reset_n    (reset_n),
        .wr_en      (trim_wr_en),
        .wr_idx     (trim_wr_idx),
        .wr_data    (trim_wr_data),
        .rd_idx     (trim_rd_idx),
        .rd_data_ff (trim_rd)
    ); // factory values at reset, read back and overwrite

    always_comb begin
        prdata = 32'h0;
        if (psel && penable && !pwrite) begin
            unique case (1'b1)
                paddr == `REG_CTRL:   prdata = ctrl_ff;
                paddr == `REG_TRIG:   prdata = {31'h0, sw_cal_start_bit};
                paddr == `REG_LP:     prdata = lp_ff;
                paddr == `REG_STATUS: prdata = {24'h0, 4'(state_ff), 3'h0, done_ff};
                is_trim(paddr):       prdata = {20'h0, trim_rd};
                default:              prdata = 32'h0;
            endcase
        end
    end

    // sequencer
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_ff  <= st_fg_bank; // power-up calibration
            cnt_ff    <= 16'(`BANK_CAL_CYC);
            bank_ff   <= 3'h0;
            os_idx_ff <= 3'h0;
            target_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                st_idle: begin
                    if (start_evt && ctrl_ff[`CTRL_CAL_EN]) begin
                        if (ctrl_ff[`CTRL_BG_EN] && !ctrl_ff[`CTRL_PIN_SEL]) begin
                            state_ff <= st_bg_run;
                            cnt_ff   <= 16'(`BANK_CAL_CYC);
                        end else begin
                            state_ff <= st_fg_bank;
                            bank_ff  <= 3'h0;
                            cnt_ff   <= 16'(`BANK_CAL_CYC);
                        end
                    end
                end
                // each bank in turn, all six
                st_fg_bank: begin
                    if (cnt_ff != 16'h0) begin
                        cnt_ff <= cnt_ff - 16'h1;
                    end else if (bank_ff != 3'(`BANKS - 1)) begin
                        bank_ff <= bank_ff + 3'h1;
                        cnt_ff  <= 16'(`BANK_CAL_CYC);
                    end else if (ctrl_ff[`CTRL_FG_OS]) begin
                        state_ff  <= st_fg_offset; // one offset pass
                        os_idx_ff <= 3'h0;
                        cnt_ff    <= 16'(`OFFSET_CAL_CYC);
                    end else begin
                        state_ff <= st_idle;
                    end
                end
                st_fg_offset: begin
                    if (cnt_ff != 16'h0) begin
                        cnt_ff <= cnt_ff - 16'h1;
                    end else if (os_idx_ff != 3'(`TRIMS - 1)) begin
                        os_idx_ff <= os_idx_ff + 3'h1;
                        target_ff <= ~target_ff;
                        cnt_ff    <= 16'(`OFFSET_CAL_CYC);
                    end else begin
                        state_ff <= st_idle;
                    end
                end
                // spare core idle between rotations
                st_bg_run: begin
                    if (!ctrl_ff[`CTRL_BG_EN]) begin
                        state_ff <= st_idle;
                    end else if (ctrl_ff[`CTRL_LOW_POWER_BG_ENABLE]) begin
                        state_ff <= ctrl_ff[`CTRL_LP_SWITCH] ? st_bg_wait : st_bg_sleep;
                        cnt_ff   <= spare_sleep_delay;
                    end else begin
                        state_ff <= st_bg_cal;
                        cnt_ff   <= 16'(`BANK_CAL_CYC);
                    end
                end
                st_bg_sleep: begin
                    if (cnt_ff != 16'h0) begin
                        cnt_ff <= cnt_ff - 16'h1;
                    end else begin
                        state_ff <= st_bg_wake;
                        cnt_ff   <= spare_wake_delay;
                    end
                end
                // user-initiated switch in low power
                st_bg_wait: begin
                    if (!ctrl_ff[`CTRL_BG_EN]) begin
                        state_ff <= st_idle;
                    end else if (start_evt || pin_rise) begin
                        state_ff <= st_bg_wake;
                        cnt_ff   <= spare_wake_delay;
                    end
                end
                st_bg_wake: begin
                    if (cnt_ff != 16'h0) begin
                        cnt_ff <= cnt_ff - 16'h1; // settle time
                    end else begin
                        state_ff <= st_bg_cal;
                        cnt_ff   <= 16'(`BANK_CAL_CYC);
                    end
                end
                st_bg_cal: begin
                    if (cnt_ff != 16'h0) begin
                        cnt_ff <= cnt_ff - 16'h1;
                    end else begin
                        state_ff  <= st_bg_swap;
                    end
                end
                // hand over, calibrate released core next
                st_bg_swap: begin
                    target_ff <= ~target_ff;
                    state_ff  <= st_bg_run;
                end
                default: state_ff <= st_idle;
            endcase
        end
    end

    // done clears on a foreground start, sets at completion
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            done_ff <= 1'b0;
        end else if (state_ff == st_idle && start_evt && ctrl_ff[`CTRL_CAL_EN]
                     && !(ctrl_ff[`CTRL_BG_EN] && !ctrl_ff[`CTRL_PIN_SEL])) begin
            done_ff <= 1'b0;
        end else if ((state_ff == st_fg_bank && cnt_ff == 16'h0
                      && bank_ff == 3'(`BANKS - 1) && !ctrl_ff[`CTRL_FG_OS])
                     || (state_ff == st_fg_offset && cnt_ff == 16'h0
                      && os_idx_ff == 3'(`TRIMS - 1))) begin
            done_ff <= 1'b1;
        end
    end
    assign foreground_done_flag = done_ff;

    // core roles, power and bank strobes
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            core_online_ff <= 3'b000;
            core_power_ff  <= 3'b111;
            bank_cal_ff    <= 6'h00;
        end else begin
            bank_cal_ff <= 6'h00;
            if (state_ff == st_fg_bank || state_ff == st_fg_offset) begin
                core_online_ff <= 3'b000;
                core_power_ff  <= {state_ff == st_fg_bank, 2'b11};
                if (state_ff == st_fg_bank) begin
                    bank_cal_ff <= 6'(6'h01 << bank_ff);
                end
            end else if (state_ff == st_idle) begin
                core_online_ff <= 3'b011;
                core_power_ff  <= 3'b011;
            end else begin
                // calibrating core out, spare c
                if (state_ff == st_bg_cal || state_ff == st_bg_swap) begin
                    core_online_ff <= 3'b100 | (3'b011 & ~core_bit(target_ff));
                    bank_cal_ff <= target_ff ? 6'b001100 : 6'b000011;
                end else begin
                    core_online_ff <= 3'b011;
                end
                // offline core sleeps in low power
                core_power_ff <= (low_power_background_mode
                                  && (state_ff == st_bg_sleep || state_ff == st_bg_wait))
                                 ? 3'b011 : 3'b111;
            end
        end
    end

    // input routing per channel mode
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            core_a_input_ff <= 2'b00;
            core_b_input_ff <= 2'b01;
            core_c_input_ff <= 2'b00;
        end else if (ctrl_ff[`CTRL_SINGLE_CH]) begin
            core_a_input_ff <= {1'b0, ctrl_ff[`CTRL_INPUT_SEL]};
            core_b_input_ff <= {1'b0, ctrl_ff[`CTRL_INPUT_SEL]};
            core_c_input_ff <= {1'b0, ctrl_ff[`CTRL_INPUT_SEL]};
        end else begin
            core_a_input_ff <= 2'b00;
            core_b_input_ff <= 2'b01;
            core_c_input_ff <= {1'b0, target_ff};
        end
    end

    // output samples; midcode during foreground
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sample_a_ff <= `MIDCODE;
            sample_b_ff <= `MIDCODE;
        end else if (state_ff == st_fg_bank || state_ff == st_fg_offset) begin
            sample_a_ff <= `MIDCODE;
            sample_b_ff <= `MIDCODE;
        end else if (state_ff == st_bg_cal || state_ff == st_bg_swap) begin
            sample_a_ff <= target_ff ? core_a_data : core_c_data;
            sample_b_ff <= target_ff ? core_c_data : core_b_data;
        end else begin
            sample_a_ff <= core_a_data;
            sample_b_ff <= core_b_data;
        end
    end
endmodule

// [cal_seq_consts.svh]
/*
 * register offsets, field positions, reset values and timing counts
 * for the calibration sequencer; included by the design, checker and bench files
 */
`ifndef CAL_SEQ_CONSTS_SVH
`define CAL_SEQ_CONSTS_SVH

`define REG_CTRL            12'h000
`define REG_TRIG            12'h004
`define REG_LP              12'h008
`define REG_STATUS          12'h00c
`define REG_TRIM_BASE       12'h010
`define REG_TRIM_LAST       12'h024

`define CTRL_CAL_EN         0
`define CTRL_PIN_SEL        1
`define CTRL_BG_EN          2
`define CTRL_LOW_POWER_BG_ENABLE          3
`define CTRL_LP_SWITCH      4
`define CTRL_FG_OS          5
`define CTRL_BG_OS          6
`define CTRL_SINGLE_CH      7
`define CTRL_INPUT_SEL      8

`define LP_SLEEP_LSB        0
`define LP_WAKE_LSB         16

`define CTRL_RESET          32'h0000_0001
`define LP_RESET            32'h0010_0010
`define TRIM_FACTORY        12'h800

`define MIDCODE             12'h000
`define BANK_CAL_NS         100
`define BANK_CAL_CYC        ((`BANK_CAL_NS + 4) / 5)
`define OFFSET_CAL_NS       400
`define OFFSET_CAL_CYC      ((`OFFSET_CAL_NS + 4) / 5)
`define BANKS               6
`define TRIMS               6

`endif

// [cal_seq_pkg.sv]
/*
 * types shared by the calibration sequencer files
 * assumes cal_seq_consts.svh is on the include path
 */
package cal_seq_pkg;
    typedef enum logic [3:0] {
        st_idle      = 4'b0000,
        st_fg_bank   = 4'b0001,
        st_fg_offset = 4'b0010,
        st_bg_run    = 4'b0011,
        st_bg_sleep  = 4'b0100,
        st_bg_wait   = 4'b0101,
        st_bg_wake   = 4'b0110,
        st_bg_cal    = 4'b0111,
        st_bg_swap   = 4'b1000
    } cal_state_e;

    typedef logic [11:0] sample_t;
endpackage

// [trim_store.sv]
/*
 * offset trim memory: software and the calibration engine share it;
 * read data registered; factory values load at reset
 * assumes one write port per cycle, engine writes win over software
 */
`timescale 1ns/1ps
`include "cal_seq_consts.svh"

module trim_store
    import cal_seq_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // write port
    input  wire logic        wr_en,
    input  wire logic [2:0]  wr_idx,
    input  wire logic [11:0] wr_data,
    // read port
    input  wire logic [2:0]  rd_idx,
    output logic      [11:0] rd_data_ff
);
    logic [11:0] mem_ff [`TRIMS];

    genvar g;
    generate
        for (g = 0; g < `TRIMS; g++) begin : g_word
            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    mem_ff[g] <= `TRIM_FACTORY;
                end else if (wr_en && wr_idx == 3'(g)) begin
                    mem_ff[g] <= wr_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_ff <= 12'h000;
        end else if (rd_idx < 3'(`TRIMS)) begin
            rd_data_ff <= mem_ff[rd_idx];
        end else begin
            rd_data_ff <= 12'h000;
        end
    end
endmodule

// [cal_seq_props.sv]
/* port checker for the calibration sequencer
 * assumes bind onto adc_calibration_sequencer, constants header on the path */
`timescale 1ns/1ps
`include "cal_seq_consts.svh"

module cal_seq_props (
    // clock and reset
    input wire logic        clock,
    input wire logic        reset_n,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // converter side
    input wire logic [11:0] sample_a_ff,
    input wire logic [11:0] sample_b_ff,
    input wire logic [2:0]  core_online_ff,
    input wire logic [2:0]  core_power_ff,
    input wire logic [5:0]  bank_cal_ff,
    input wire logic        foreground_done_flag
);
    logic       acc;
    logic [5:0] on_banks;
    logic [5:0] pwr_banks;
    assign acc       = psel & penable;
    // banks pair into cores: bits 1:0 core a, 3:2 core b, 5:4 core c
    assign on_banks  = {{2{core_online_ff[2]}}, {2{core_online_ff[1]}}, {2{core_online_ff[0]}}};
    assign pwr_banks = {{2{core_power_ff[2]}}, {2{core_power_ff[1]}}, {2{core_power_ff[0]}}};

    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    property p_ready;
        acc |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("access without ready");
    property p_unmapped;
        acc && paddr > `REG_TRIM_LAST |-> pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not flagged");
    property p_idle_rd;
        !acc |-> prdata == 32'h0;
    endproperty
    a_idle_rd: assert property (p_idle_rd) else $error("read data outside access");
    property p_status;
        acc && !pwrite && paddr == `REG_STATUS |-> prdata[0] == foreground_done_flag;
    endproperty
    a_status: assert property (p_status) else $error("status bit differs from flag");
    property p_midcode;
        (core_online_ff == 3'b000) [*2] |-> sample_a_ff == `MIDCODE && sample_b_ff == `MIDCODE;
    endproperty
    a_midcode: assert property (p_midcode) else $error("samples not midcode offline");
    property p_done_fall;
        $fell(foreground_done_flag) |-> ##[1:3] sample_a_ff == `MIDCODE;
    endproperty
    a_done_fall: assert property (p_done_fall) else $error("no midcode after start");
    property p_onehot;
        $onehot0(bank_cal_ff) || bank_cal_ff inside {6'h03, 6'h0c};
    endproperty
    a_onehot: assert property (p_onehot) else $error("several banks in calibration");
    property p_cal_off;
        (bank_cal_ff & on_banks) == 6'h00;
    endproperty
    a_cal_off: assert property (p_cal_off) else $error("online bank in calibration");
    property p_cal_pwr;
        (bank_cal_ff & ~pwr_banks) == 6'h00;
    endproperty
    a_cal_pwr: assert property (p_cal_pwr) else $error("unpowered bank calibrated");
    property p_online_pwr;
        (core_online_ff & ~core_power_ff) == 3'b000;
    endproperty
    a_online_pwr: assert property (p_online_pwr) else $error("online core unpowered");
    property p_two_online;
        core_online_ff != 3'b000 |-> $countones(core_online_ff) >= 2;
    endproperty
    a_two_online: assert property (p_two_online) else $error("fewer than two cores");
    property p_bank_hold;
        $rose(bank_cal_ff[0]) |-> bank_cal_ff[0] [*8];
    endproperty
    a_bank_hold: assert property (p_bank_hold) else $error("bank step cut short");
endmodule

bind adc_calibration_sequencer cal_seq_props cal_seq_props_inst (
    .clock, .reset_n, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .sample_a_ff, .sample_b_ff, .core_online_ff, .core_power_ff, .bank_cal_ff,
    .foreground_done_flag
);

// [cal_host_model.sv]
/* system controller model: start pin pulse of chosen length, muted core data
 * assumes requests arrive just after a rising edge */
`timescale 1ns/1ps

module cal_host_model (
    // clock and reset
    input wire logic        clock,
    input wire logic        reset_n,
    // requests from the bench
    input wire logic        pulse_req,
    input wire logic [3:0]  hold_cyc,
    input wire logic [11:0] level,
    // far side
    output logic            cal_start_pin,
    output logic     [11:0] core_a_data,
    output logic     [11:0] core_b_data,
    output logic     [11:0] core_c_data
);
    logic [3:0] cnt_ff;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n)
            cnt_ff <= 4'h0;
        else if (pulse_req)
            cnt_ff <= hold_cyc;
        else if (cnt_ff != 4'h0)
            cnt_ff <= cnt_ff - 4'h1;
    end
    // level pin, its rising edge is the start
    assign cal_start_pin = (cnt_ff != 4'h0);
    // input muted: only the buffer offset remains
    assign core_a_data   = level;
    assign core_b_data   = level;
    assign core_c_data   = level;
endmodule

// [tb_top.sv]
/* self-checking bench for the calibration sequencer: apb master, register model
 * assumes header, package, design, checker and host model compile first */
`timescale 1ns/1ps
`include "cal_seq_consts.svh"

module tb_top
    import cal_seq_pkg::*;
;
    logic        clock, reset_n, psel, penable, pwrite, pready, pslverr, err;
    logic        cal_start_pin, pulse_req, foreground_done_flag;
    logic [11:0] paddr, level, core_a_data, core_b_data, core_c_data, sample_a_ff, sample_b_ff;
    logic [31:0] pwdata, prdata, rd, t;
    logic [3:0]  hold_cyc;
    logic [2:0]  core_online_ff, core_power_ff, prev;
    logic [5:0]  bank_cal_ff, seen;
    logic [1:0]  core_a_input_ff, core_b_input_ff, core_c_input_ff;
    int          mismatches, num_checks, cycles, seed, i, n, zc, chg, pd;
    int          exp_reg [0:9];

    adc_calibration_sequencer adc_calibration_sequencer_inst (
        .clock, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .cal_start_pin, .core_a_data, .core_b_data, .core_c_data, .sample_a_ff,
        .sample_b_ff, .core_online_ff, .core_power_ff, .bank_cal_ff, .core_a_input_ff,
        .core_b_input_ff, .core_c_input_ff, .foreground_done_flag
    );
    cal_host_model cal_host_model_inst (
        .clock, .reset_n, .pulse_req, .hold_cyc, .level, .cal_start_pin, .core_a_data,
        .core_b_data, .core_c_data
    );

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(negedge clock) seen <= seen | bank_cal_ff;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            report_and_stop;
        end
    end

    task automatic report_and_stop;
        if (mismatches == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        num_checks++;
        if (got !== want) begin
            mismatches++;
            $display("ERROR time=%0t seen=%h expected=%h", $time, got, want);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        exp_reg[a >> 2] = d;
    endtask
    task automatic rdm(input int k);
        apb(1'b0, 12'(k * 4), 32'h0);
        chk(rd, exp_reg[k]);
    endtask
    // waits out a foreground calibration just started
    task automatic run_fg;
        int k;
        k = 0;
        seen = 6'h00;
        while (foreground_done_flag !== 1'b0 && k < 8) begin
            @(posedge clock);
            k++;
        end
        chk(foreground_done_flag, 1'b0);
        repeat (2) @(posedge clock);
        chk({sample_b_ff, sample_a_ff, core_online_ff}, 32'h0);
        while (foreground_done_flag !== 1'b1) @(posedge clock);
        chk(seen, 6'h3f);
    endtask
    task automatic watch(input int cyc);
        zc = 0;
        chg = 0;
        pd = 0;
        prev = core_online_ff;
        repeat (cyc) begin
            @(posedge clock);
            if (core_online_ff === 3'b000) zc++;
            if (core_online_ff !== prev) chg++;
            if (core_power_ff !== 3'b111) pd++;
            prev = core_online_ff;
        end
    endtask
    task automatic soft_start;
        wr(`REG_TRIG, 32'h0);
        wr(`REG_TRIG, 32'h1);
    endtask

    initial begin
        seed = 32'hdb6407d6;
        n = $random(seed);
        level = {1'b0, n[10:0]} | 12'h001;
        {psel, penable, pwrite, pulse_req} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        hold_cyc = 4'h1;
        reset_n = 1'b0;
        seen = 6'h00;
        for (i = 0; i < 10; i++) exp_reg[i] = (i < 4) ? 0 : `TRIM_FACTORY;
        exp_reg[0] = `CTRL_RESET;
        exp_reg[2] = `LP_RESET;
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        run_fg;
        chk({core_a_input_ff, core_b_input_ff}, 4'b0001);
        for (i = 0; i < 10; i++) if (i != 3) rdm(i);
        apb(1'b0, `REG_STATUS, 32'h0);
        chk(rd[0], 1'b1);
        apb(1'b1, 12'h028, 32'h1);
        chk(err, 1'b1);
        for (i = 4; i < 10; i++) begin
            n = $random(seed);
            wr(12'(i * 4), n & 32'hfff);
            rdm(i);
        end
        wr(`REG_CTRL, 32'h181);
        soft_start;
        run_fg;
        chk({core_a_input_ff, core_b_input_ff, core_c_input_ff}, 6'b010101);
        wr(`REG_CTRL, 32'h003);
        soft_start;
        repeat (4) @(posedge clock);
        chk(foreground_done_flag, 1'b1);
        pulse_req <= 1'b1;
        hold_cyc <= 4'h9;
        @(posedge clock);
        pulse_req <= 1'b0;
        run_fg;
        wr(`REG_CTRL, 32'h020);
        wr(`REG_CTRL, 32'h021);
        soft_start;
        run_fg;
        n = 0;
        for (i = 4; i < 10; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0);
            if (rd === {20'h0, -level}) n++;
        end
        chk(n, 6);
        apb(1'b0, `REG_TRIM_BASE, 32'h0);
        t = rd;
        apb(1'b1, `REG_TRIM_BASE, ~t & 32'hfff);
        apb(1'b0, `REG_TRIM_BASE, 32'h0);
        chk(rd, t);
        n = $random(seed);
        wr(`REG_LP, (n & 32'h000f_000f) | 32'h0008_0008);
        rdm(2);
        wr(`REG_CTRL, 32'h04d);
        soft_start;
        watch(3000);
        chk(zc, 0);
        chk(sample_a_ff, level);
        chk(chg > 1, 1'b1);
        chk(pd != 0, 1'b1);
        wr(`REG_CTRL, 32'h05d);
        watch(400);
        watch(800);
        chk(chg, 0);
        soft_start;
        watch(800);
        chk(chg != 0, 1'b1);
        report_and_stop;
    end
endmodule
